// ### rtl/timer8_pwm_pkg.sv
// package for the 8-bit period / pwm timer: register map, field layout,
// reset values and the fixed encodings of the control fields.
// assumes an apb slave with 32-bit data, one register per aligned word.
`default_nettype none

package timer8_pwm_pkg;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] ADDR_CONTROL    = 12'h000;  // source, route, mode
   localparam logic [11:0] ADDR_BOUND      = 12'h004;  // bound value
   localparam logic [11:0] ADDR_SCALE      = 12'h008;  // resolution, prescale, scaler
   localparam logic [11:0] ADDR_COUNT      = 12'h00C;  // live counter

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTL_SRC_MSB  = 7;   // clock source select
   localparam int CTL_SRC_LSB  = 4;
   localparam int CTL_OUT_MSB  = 3;   // output pin route
   localparam int CTL_OUT_LSB  = 2;
   localparam int CTL_MODE_BIT = 1;   // 1 = pwm, 0 = period
   localparam int SCL_RES_BIT  = 7;   // 1 = reduced resolution pwm
   localparam int SCL_PRE_MSB  = 6;   // prescaler select
   localparam int SCL_PRE_LSB  = 5;
   localparam int SCL_DIV_MSB  = 4;   // scaler value
   localparam int SCL_DIV_LSB  = 0;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] BOUND_RST   = 8'h00;
   localparam logic [7:0] SCALE_RST   = 8'h00;
   localparam logic [7:0] COUNT_RST   = 8'h00;

   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   localparam logic [3:0] SRC_STOP      = 4'h0;  // no clock, timer frozen
   localparam logic [3:0] SRC_SYSCLK    = 4'h1;  // every pclk cycle
   localparam logic [3:0] SRC_EXT_FIRST = 4'h2;  // 2..7: rising edges of ext inputs
   localparam logic [1:0] OUT_NONE      = 2'h0;  // no pin driven
   localparam logic [1:0] OUT_PIN_A     = 2'h1;
   localparam logic [1:0] OUT_PIN_THREE = 2'h2;  // port_pin_three
   localparam logic [1:0] OUT_PIN_C     = 2'h3;
   localparam logic [5:0] PRE_LIM_1     = 6'h00; // last prescale count, /1
   localparam logic [5:0] PRE_LIM_4     = 6'h03;
   localparam logic [5:0] PRE_LIM_16    = 6'h0F;
   localparam logic [5:0] PRE_LIM_64    = 6'h3F;
   localparam logic [7:0] MASK_8BIT     = 8'hFF; // pwm period masks
   localparam logic [7:0] MASK_7BIT     = 8'h7F;
   localparam logic [7:0] MASK_6BIT     = 8'h3F;

endpackage

`default_nettype wire

// ### rtl/timer8_period_pwm.sv
// 8-bit up-counting timer with period (square wave) and pwm modes,
// reached over apb, driving one of three routed output pins.
// assumes pclk at 10 MHz, async active-low presetn, ext sources async.
//
// Design decisions made here: the address map and the APB interface to the registers.
`default_nettype none

module timer8_period_pwm
   import timer8_pwm_pkg::*;
#(
   parameter int N_EXT    = 6,    // external clock source inputs
   parameter bit RES7_OPT = 1'b0  // pwm_resolution_option: 7-bit reduced mode
)
(
   // clock and reset
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   // apb slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [timer8_pwm_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                         pwdata,
   output logic      [31:0]                         prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   // asynchronous clock sources
   input  wire logic [N_EXT-1:0]                    ext_src_in,
   // routed output pins
   output logic                                     pin_a_o,
   output logic                                     pin_a_oe,
   output logic                                     port_pin_three_o,
   output logic                                     port_pin_three_oe,
   output logic                                     pin_c_o,
   output logic                                     pin_c_oe
);
   import timer8_pwm_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       ctrl;   // timer_control
      logic [7:0]       bound;  // timer_bound
      logic [7:0]       scale;  // timer_scale
      logic [7:0]       cnt;    // timer_count_value
      logic [5:0]       pre;    // prescaler count
      logic [4:0]       scl;    // scaler count
      logic             wave;   // timer waveform before routing
      logic [N_EXT-1:0] s1;     // sync stage 1, read by s2 only
      logic [N_EXT-1:0] s2;     // sync stage 2
      logic [N_EXT-1:0] s3;     // sync stage 3
      logic [N_EXT-1:0] stab;   // last agreed level per source
      logic [2:0]       pin;    // pin levels a, three, c
      logic [2:0]       oe;     // pin enables a, three, c
      logic [31:0]      rdata;  // apb read data
      logic             ready;  // apb pready
      logic             err;    // apb pslverr
   } state_s;

   state_s s_q;   // registered state
   state_s s_d;   // next state

   // ---------------------------------------------------------------
   // decode functions
   // ---------------------------------------------------------------
   // register index 0..3, 4 for an unmapped address
   function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [2:0] idx;
      idx = 3'h4;
      case (a)
         ADDR_CONTROL: idx = 3'h0;
         ADDR_BOUND:   idx = 3'h1;
         ADDR_SCALE:   idx = 3'h2;
         ADDR_COUNT:   idx = 3'h3;
         default:      idx = 3'h4;
      endcase
      return idx;
   endfunction

   // last prescaler count for each select code
   function automatic logic [5:0] pre_limit(input logic [1:0] sel);
      logic [5:0] lim;
      lim = PRE_LIM_1;
      case (sel)
         2'h0:    lim = PRE_LIM_1;
         2'h1:    lim = PRE_LIM_4;
         2'h2:    lim = PRE_LIM_16;
         default: lim = PRE_LIM_64;
      endcase
      return lim;
   endfunction

   // pwm counter mask from the resolution bit and the build option
   function automatic logic [7:0] pwm_mask(input logic reduced);
      logic [7:0] m;
      m = MASK_8BIT;
      if (reduced)
      begin
         m = RES7_OPT ? MASK_7BIT : MASK_6BIT;
      end
      return m;
   endfunction

   // ---------------------------------------------------------------
   // tick chain
   // ---------------------------------------------------------------
   logic [N_EXT-1:0] ext_rise;   // agreed rising edge per source
   logic [3:0]       src_sel;    // control clock source field
   logic             src_tick;   // one selected source clock
   logic             pre_tick;   // prescaler output enable
   logic             scl_tick;   // scaled timer clock enable
   logic [7:0]       mask;       // active pwm period mask
   logic             pwm_mode;   // control mode bit
   logic [1:0]       route;      // control route field

   // edge counts only once stages 2 and 3 agree, so a glitch that
   // dies in one cycle never reaches the counter
   assign ext_rise = (s_q.s2 ~^ s_q.s3) & s_q.s3 & ~s_q.stab;
   assign src_sel  = s_q.ctrl[CTL_SRC_MSB:CTL_SRC_LSB];
   assign pwm_mode = s_q.ctrl[CTL_MODE_BIT];
   assign route    = s_q.ctrl[CTL_OUT_MSB:CTL_OUT_LSB];
   assign mask     = pwm_mask(s_q.scale[SCL_RES_BIT]);

   // source select, undefined codes stop the timer
   always_comb
   begin
      src_tick = 1'b0;
      if (src_sel == SRC_SYSCLK)
      begin
         src_tick = 1'b1;
      end
      else if (src_sel >= SRC_EXT_FIRST && (32'(src_sel) - 32'(SRC_EXT_FIRST)) < N_EXT)
      begin
         src_tick = ext_rise[32'(src_sel) - 32'(SRC_EXT_FIRST)];
      end
   end

   // prescaler then scaler, each a one-cycle enable
   assign pre_tick = src_tick && (s_q.pre == pre_limit(s_q.scale[SCL_PRE_MSB:SCL_PRE_LSB]));
   assign scl_tick = pre_tick && (s_q.scl == s_q.scale[SCL_DIV_MSB:SCL_DIV_LSB]);

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic       apb_setup;  // first cycle of a transfer
   logic       apb_done;   // completing edge of a transfer
   logic [2:0] idx;        // decoded register
   logic       wr_ok;      // mapped write completing now
   logic [7:0] cnt_inc;    // counter plus one, period mode
   logic [7:0] cnt_wrap;   // masked counter plus one, pwm mode

   assign apb_setup = psel && !penable;
   assign apb_done  = psel && penable && s_q.ready;
   assign idx       = reg_index(paddr);
   assign wr_ok     = apb_done && pwrite && !s_q.err;
   assign cnt_inc   = 8'(s_q.cnt + 8'h01);
   assign cnt_wrap  = cnt_inc & mask;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;

      // three-stage synchroniser and agreed level
      s_d.s1 = ext_src_in;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      for (int i = 0; i < N_EXT; i++)
      begin
         if (s_q.s2[i] == s_q.s3[i])
         begin
            s_d.stab[i] = s_q.s3[i];
         end
      end

      // prescaler and scaler counts
      if (src_tick)
      begin
         s_d.pre = pre_tick ? 6'h00 : 6'(s_q.pre + 6'h01);
      end
      if (pre_tick)
      begin
         s_d.scl = scl_tick ? 5'h00 : 5'(s_q.scl + 5'h01);
      end

      // timer counter; a software write beats a same-cycle tick
      if (wr_ok && idx == 3'h3)
      begin
         s_d.cnt = pwdata[7:0];
      end
      else if (scl_tick)
      begin
         if (!pwm_mode)
         begin
            // bound compared as unsigned K; half period is K+1 ticks
            if (s_q.cnt == s_q.bound)
            begin
               s_d.cnt  = 8'h00;
               s_d.wave = ~s_q.wave;
            end
            else
            begin
               s_d.cnt = cnt_inc;
            end
         end
         else
         begin
            // pwm wraps at 256, 128 or 64; high for counts 0..bound,
            // so a bound at or over the mask keeps the pin high
            s_d.cnt  = cnt_wrap;
            s_d.wave = (cnt_wrap <= s_q.bound);
         end
      end

      // register writes, reserved control bit 0 not stored
      if (wr_ok)
      begin
         case (idx)
            3'h0:    s_d.ctrl  = {pwdata[7:1], 1'b0};
            3'h1:    s_d.bound = pwdata[7:0];
            3'h2:    s_d.scale = pwdata[7:0];
            default: s_d.ctrl  = s_d.ctrl;
         endcase
      end

      // output routing, unselected pins are released
      for (int p = 0; p < 3; p++)
      begin
         s_d.oe[p]  = (route == 2'(p + 1));
         s_d.pin[p] = s_q.wave && (route == 2'(p + 1));
      end

      // apb: ready one cycle after setup, data captured at setup
      if (apb_setup)
      begin
         s_d.ready = 1'b1;
         s_d.err   = (idx == 3'h4);
         case (idx)
            3'h0:    s_d.rdata = {24'h000000, s_q.ctrl};
            3'h1:    s_d.rdata = {24'h000000, s_q.bound};
            3'h2:    s_d.rdata = {24'h000000, s_q.scale};
            3'h3:    s_d.rdata = {24'h000000, s_q.cnt};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      else if (apb_done)
      begin
         s_d.ready = 1'b0;
         s_d.err   = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // all control state starts from constants
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q       <= '0;
         s_q.ctrl  <= CONTROL_RST;
         s_q.bound <= BOUND_RST;
         s_q.scale <= SCALE_RST;
         s_q.cnt   <= COUNT_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign prdata            = s_q.rdata;
   assign pready            = s_q.ready;
   assign pslverr           = s_q.err;
   assign pin_a_o           = s_q.pin[0];
   assign pin_a_oe          = s_q.oe[0];
   assign port_pin_three_o  = s_q.pin[1];
   assign port_pin_three_oe = s_q.oe[1];
   assign pin_c_o           = s_q.pin[2];
   assign pin_c_oe          = s_q.oe[2];

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic cnt_wr;  // software counter write completing
   assign cnt_wr = wr_ok && idx == 3'h3;

   a_period_clear: assert property (
      (scl_tick && !pwm_mode && s_q.cnt == s_q.bound && !cnt_wr) |=> (s_q.cnt == 8'h00))
      else $error("counter not cleared at bound in period mode");

   a_period_toggle: assert property (
      (scl_tick && !pwm_mode && s_q.cnt == s_q.bound && !cnt_wr)
      |=> (s_q.wave != $past(s_q.wave)))
      else $error("waveform did not toggle at bound");

   a_period_hold: assert property (
      (!pwm_mode && !scl_tick) |=> $stable(s_q.wave))
      else $error("period waveform changed without a scaled tick");

   a_pwm8_full: assert property (
      (scl_tick && pwm_mode && !s_q.scale[SCL_RES_BIT] && s_q.bound == 8'hFF && !cnt_wr)
      |=> s_q.wave)
      else $error("8-bit pwm with bound 255 went low");

   a_pwm6_full: assert property (
      (scl_tick && pwm_mode && s_q.scale[SCL_RES_BIT] && !RES7_OPT && s_q.bound == 8'h3F
      && !cnt_wr)
      |=> s_q.wave)
      else $error("reduced pwm with bound 63 went low");

   a_pwm_low: assert property (
      (scl_tick && pwm_mode && cnt_wrap > s_q.bound && !cnt_wr) |=> !s_q.wave)
      else $error("pwm high past bound");

   a_pwm8_wrap: assert property (
      (scl_tick && pwm_mode && !s_q.scale[SCL_RES_BIT] && s_q.cnt == 8'hFF && !cnt_wr)
      |=> (s_q.cnt == 8'h00))
      else $error("8-bit pwm did not wrap after 255");

   a_pwm_reduced_wrap: assert property (
      (scl_tick && pwm_mode && s_q.scale[SCL_RES_BIT] && s_q.cnt == mask && !cnt_wr)
      |=> (s_q.cnt == 8'h00 && $past(mask) == (RES7_OPT ? 8'h7F : 8'h3F)))
      else $error("reduced pwm did not wrap at its period");

   a_route_three: assert property (
      (route == OUT_PIN_THREE)[*2] |-> (port_pin_three_oe && !pin_a_oe && !pin_c_oe
      && port_pin_three_o == $past(s_q.wave)))
      else $error("output not routed to pin three");

   a_scaler_tick: assert property (
      scl_tick |-> (s_q.scl == s_q.scale[SCL_DIV_MSB:SCL_DIV_LSB] && pre_tick))
      else $error("scaled tick without scaler match");

   a_source_stop: assert property (
      (src_sel == SRC_STOP) |-> !src_tick)
      else $error("timer clocked while source stopped");

   a_count_write: assert property (
      cnt_wr |=> (s_q.cnt == $past(pwdata[7:0])))
      else $error("counter write lost");

   a_apb_ready: assert property (
      apb_setup |=> (pready ##1 !pready))
      else $error("apb ready not one cycle after setup");

   c_period_toggle: cover property (
      scl_tick && !pwm_mode && s_q.cnt == s_q.bound ##1 scl_tick && !pwm_mode);
   c_pwm_full: cover property (
      pwm_mode && s_q.bound == 8'hFF && scl_tick);
   c_count_write: cover property (cnt_wr);
   c_pin_three: cover property (port_pin_three_oe && port_pin_three_o);

endmodule

`default_nettype wire

// ### testbench/timer8_period_pwm_tb_top.sv
// self-checking bench for the 8-bit period / pwm timer: apb register
// tasks, wave timing on the routed pins, and one closing verdict.
// assumes timer8_pwm_pkg is compiled first and pclk runs at 100 ns.
`default_nettype none

module timer8_period_pwm_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import timer8_pwm_pkg::*;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int LIM = 20000;            // cycle bound for the waits of one wave measurement
   logic        pclk     = 1'b0;          // 10 MHz bus clock
   logic        presetn  = 1'b0;          // held low for two cycles
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [11:0] ext_cnt  = 12'h000;       // free counter feeding sources
   logic [5:0]  ext_src_in;
   logic        pin_a_o;
   logic        pin_a_oe;
   logic        port_pin_three_o;
   logic        port_pin_three_oe;
   logic        pin_c_o;
   logic        pin_c_oe;
   logic [1:0]  sel      = 2'h2;          // route code of the watched pin
   logic        cur_pin;
   logic [31:0] rdv;
   logic        errv;
   int          fails    = 0;
   int          compares = 0;

   // ---------------------------------------------------------------
   // clock, sources and watched pin
   // ---------------------------------------------------------------
   always #50 pclk = ~pclk;

   // bit k of the sources has a period of 32 << k cycles, so a wrong
   // source index shows up as a wrong wave length
   always @(posedge pclk)
      ext_cnt <= ext_cnt + 12'h001;
   assign ext_src_in = ext_cnt[9:4];
   assign cur_pin = (sel == 2'h1) ? pin_a_o : (sel == 2'h3) ? pin_c_o : port_pin_three_o;

   timer8_period_pwm #(.N_EXT(6), .RES7_OPT(1'b0)) u_timer8_period_pwm
   (
      .pclk              (pclk),
      .presetn           (presetn),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .paddr             (paddr),
      .pwdata            (pwdata),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .ext_src_in        (ext_src_in),
      .pin_a_o           (pin_a_o),
      .pin_a_oe          (pin_a_oe),
      .port_pin_three_o  (port_pin_three_o),
      .port_pin_three_oe (port_pin_three_oe),
      .pin_c_o           (pin_c_o),
      .pin_c_oe          (pin_c_oe)
   );

   // ---------------------------------------------------------------
   // reporting
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic timeout(input string s);
      fails++;
      $display("[ERR] %0t wait ran out in %s", $time, s);
      close_out();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic done(input string s);
      $display("test %s ended, fails so far %0d", s, fails);
   endtask

   // ---------------------------------------------------------------
   // apb master: entered just after a rising edge; pready and read
   // data are taken at the rising edge, before its flops update
   // ---------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20)
         timeout("apb");
      rdv  = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle cycle keeps psel from being assigned twice in one step
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdv, e, "read data");
      chk({31'h0, errv}, {31'h0, ee}, "slave error");
   endtask

   task automatic cfg(input logic [7:0] ctl, input logic [7:0] bnd, input logic [7:0] scl);
      wr(ADDR_BOUND, {24'h0, bnd});
      wr(ADDR_SCALE, {24'h0, scl});
      wr(ADDR_CONTROL, {24'h0, ctl});
   endtask

   // ---------------------------------------------------------------
   // wave timing: skip any partial high, then time one full high and
   // the low after it, in pclk cycles
   // ---------------------------------------------------------------
   task automatic wave(input int eh, input int el);
      int hi;
      int lo;
      int n;
      hi = 0;
      lo = 0;
      n  = 0;
      @(negedge pclk);
      while (cur_pin !== 1'b0 && n < LIM)
      begin
         @(negedge pclk);
         n++;
      end
      while (cur_pin !== 1'b1 && n < LIM)
      begin
         @(negedge pclk);
         n++;
      end
      while (cur_pin === 1'b1 && n < LIM)
      begin
         @(negedge pclk);
         hi++;
         n++;
      end
      while (cur_pin === 1'b0 && n < LIM)
      begin
         @(negedge pclk);
         lo++;
         n++;
      end
      if (n >= LIM)
         timeout("wave");
      chk(hi, eh, "high time");
      chk(lo, el, "low time");
      @(posedge pclk);
   endtask

   task automatic stays_high(input int cyc);
      int bad;
      bad = 0;
      repeat (cyc)
      begin
         @(negedge pclk);
         if (cur_pin !== 1'b1)
            bad++;
      end
      chk(bad, 0, "steady high");
      @(posedge pclk);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(ADDR_CONTROL, {24'h0, CONTROL_RST}, 1'b0);
      rd_chk(ADDR_BOUND, {24'h0, BOUND_RST}, 1'b0);
      rd_chk(ADDR_SCALE, {24'h0, SCALE_RST}, 1'b0);
      rd_chk(ADDR_COUNT, {24'h0, COUNT_RST}, 1'b0);
      done("reset");
      // register access, upper bits dropped, reserved bit reads 0
      wr(ADDR_CONTROL, 32'hFFFF_FFFF);
      rd_chk(ADDR_CONTROL, 32'h0000_00FE, 1'b0);
      wr(ADDR_BOUND, 32'h1234_56A5);
      rd_chk(ADDR_BOUND, 32'h0000_00A5, 1'b0);
      wr(ADDR_SCALE, 32'h0000_00C3);
      rd_chk(ADDR_SCALE, 32'h0000_00C3, 1'b0);
      // source code 15 is stopped, so the written count must hold
      wr(ADDR_COUNT, 32'h0000_005A);
      rd_chk(ADDR_COUNT, 32'h0000_005A, 1'b0);
      wr(12'h010, 32'h0000_0011);
      rd_chk(12'h010, 32'h0000_0000, 1'b1);
      rd_chk(ADDR_CONTROL, 32'h0000_00FE, 1'b0);
      done("registers");
      // period mode on port_pin_three from pclk
      cfg(8'h18, 8'h01, 8'h00);
      wave(2, 2);
      chk({31'h0, port_pin_three_oe}, 32'h1, "pin three enable");
      chk({31'h0, pin_a_oe}, 32'h0, "pin a enable");
      cfg(8'h18, 8'h03, 8'h22);
      wave(48, 48);
      for (int p = 0; p < 4; p++)
      begin
         cfg(8'h18, 8'h00, {1'b0, p[1:0], 5'h00});
         wave(1 << (2 * p), 1 << (2 * p));
      end
      cfg(8'h18, 8'h00, 8'h1F);
      wave(32, 32);
      done("period");
      // output routing
      sel = 2'h1;
      cfg(8'h14, 8'h00, 8'h1F);
      wave(32, 32);
      chk({31'h0, port_pin_three_oe}, 32'h0, "pin three enable");
      sel = 2'h3;
      cfg(8'h1C, 8'h00, 8'h1F);
      wave(32, 32);
      chk({30'h0, pin_c_oe, pin_a_oe}, 32'h2, "pin enables");
      cfg(8'h10, 8'h00, 8'h1F);
      repeat (2) @(posedge pclk);
      chk({29'h0, pin_c_oe, port_pin_three_oe, pin_a_oe}, 32'h0, "no route");
      done("route");
      // external sources, one per source code
      sel = 2'h2;
      for (int k = 0; k < 6; k++)
      begin
         cfg({k[3:0] + 4'h2, 4'h8}, 8'h00, 8'h00);
         wave(32 << k, 32 << k);
      end
      done("sources");
      // 8-bit and 6-bit pwm
      cfg(8'h1A, 8'h09, 8'h00);
      wave(10, 246);
      cfg(8'h1A, 8'hFF, 8'h00);
      stays_high(600);
      cfg(8'h1A, 8'h1F, 8'h80);
      wave(32, 32);
      cfg(8'h1A, 8'h00, 8'h80);
      wave(1, 63);
      cfg(8'h1A, 8'h3F, 8'h80);
      stays_high(200);
      done("pwm");
      close_out();
   end

endmodule

`default_nettype wire
